// [csss_clock_startup.sv]
// Clock-source decode, start-up and reset delay timing, RC trim register.
// Assumes an AHB-Lite master on one 40 MHz clock; oscillator edges come as ticks.
// The analog amplifier and the oscillators themselves live outside this block.
// How it works
// - Upper select bits pick crystal range.
// - Low bit 0, field 00/01: 258-cycle wake.
// - 0/10, 0/11, 1/00 give 1K wake.
// - Low bit 1, 01..11 give 16K wake.
// - Select 0010 picks internal RC oscillator.
// - RC: 6-cycle wake, field sets reset delay.
// - Reset-pin disable lengthens shortest RC delay.
// - Shipped: RC, field 10, divide by eight.
// - Reset loads factory trim value.
// - Software trim writes take effect immediately.
// - Trim bit 7 picks oscillator range.
// - Trim bits 6..0 are monotonic fine trim.
// - Watchdog oscillator times the reset time-out.
// - Reset time part is none, 4K or 64K watchdog cycles.
// - Wake start-up counts selected source cycles.
`timescale 1ns/100ps
`include "csss_defines.svh"
module csss_clock_startup
  import csss_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] clk_src_sel_fuse_i,
  input wire logic [1:0] startup_time_sel_i,
  input wire logic div_by_eight_fuse_n_i,
  input wire logic reset_pin_disable_fuse_n_i,
  input wire logic fuses_blank_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic wdt_osc_tick_i,
  input wire logic src_osc_tick_i,
  input wire logic wake_req_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [7:0] rc_osc_trim_o,
  output logic [1:0] xtal_range_o,
  output logic [1:0] clk_src_o,
  output logic [1:0] sys_div_log2_o,
  output logic cpu_run_o
);
  logic [3:0] sel_q;
  logic [1:0] sut_q;
  logic div8_q;
  logic rstdis_q;
  logic strap_pend_q;
  logic [7:0] trim_q;
  logic trim_load_q;
  csss_state_t state_q;
  logic ck_phase_q;
  logic [1:0] xrange_q;
  logic [1:0] src_q;
  logic [1:0] div_q;
  logic run_q;
  logic [31:0] rdata_q;
  logic ap_valid_q;
  logic ap_write_q;
  logic [7:0] ap_addr_q;
  logic wake_seen_q;
  logic hready_q;
  logic hresp_q;
  logic trim_wr;
  logic sut_reserved;
  csss_src_t src;
  csss_cnt_t wake_cycles;
  csss_cnt_t rst_wdt_cycles;
  csss_cnt_if cif ();

  // Maps a four-bit select to the source class.
  function automatic csss_src_t decode_src(input logic [3:0] sel);
    if (sel >= `CSSS_XT_MIN) begin
      decode_src = CSSS_SRC_XTAL;
    end else if (sel == `CSSS_SEL_RC) begin
      decode_src = CSSS_SRC_RC;
    end else begin
      decode_src = CSSS_SRC_OTHER;
    end
  endfunction

  // Maps the three upper select bits to a crystal frequency range.
  function automatic csss_xrange_t decode_range(input logic [2:0] r);
    case (r)
      `CSSS_XT_R0: decode_range = CSSS_XR_LOW;
      `CSSS_XT_R1: decode_range = CSSS_XR_MID;
      `CSSS_XT_R2: decode_range = CSSS_XR_HIGH;
      `CSSS_XT_R3: decode_range = CSSS_XR_TOP;
      default: decode_range = CSSS_XR_LOW;
    endcase
  endfunction

  // True when the bus offers a transfer to this slave on this edge.
  // Idle and busy cycles carry no request and are not decoded.
  function automatic logic bus_take(input logic sel, input logic [1:0] trans, input logic rdy);
    bus_take = rdy && sel && trans[1];
  endfunction

  // Range code 100 is meant for ceramic resonators; the block only decodes it.
  assign src = decode_src(sel_q);
  assign sut_reserved = (src == CSSS_SRC_RC) && (sut_q == `CSSS_SUT_11);

  // Wake start-up length in selected-source cycles.
  // Every source other than the crystal needs only the short count before code resumes.
  always_comb begin
    wake_cycles = `CSSS_CK_6;
    if (src == CSSS_SRC_XTAL) begin
      if (!sel_q[0] && (sut_q == `CSSS_SUT_00 || sut_q == `CSSS_SUT_01)) begin
        wake_cycles = `CSSS_CK_258;
      end else if (!sel_q[0] || sut_q == `CSSS_SUT_00) begin
        wake_cycles = `CSSS_CK_1K;
      end else begin
        wake_cycles = `CSSS_CK_16K;
      end
    end else begin
      wake_cycles = `CSSS_CK_6;
    end
  end

  // Timed part of the reset delay, in watchdog oscillator cycles; zero means none.
  // The watchdog oscillator times it because the selected source may not be stable yet.
  // A programmed reset-pin disable keeps every RC setting except the reserved field 11 from falling to the bare 14 cycles.
  always_comb begin
    rst_wdt_cycles = '0;
    if (src == CSSS_SRC_XTAL) begin
      case ({sel_q[0], sut_q})
        3'h0: rst_wdt_cycles = `CSSS_WDT_4K;
        3'h1: rst_wdt_cycles = `CSSS_WDT_64K;
        3'h2: rst_wdt_cycles = '0;
        3'h3: rst_wdt_cycles = `CSSS_WDT_4K;
        3'h4: rst_wdt_cycles = `CSSS_WDT_64K;
        3'h5: rst_wdt_cycles = '0;
        3'h6: rst_wdt_cycles = `CSSS_WDT_4K;
        3'h7: rst_wdt_cycles = `CSSS_WDT_64K;
        default: rst_wdt_cycles = '0;
      endcase
    end else begin
      case (sut_q)
        `CSSS_SUT_00: rst_wdt_cycles = rstdis_q ? `CSSS_WDT_4K : '0;
        `CSSS_SUT_01: rst_wdt_cycles = `CSSS_WDT_4K;
        `CSSS_SUT_10: rst_wdt_cycles = `CSSS_WDT_64K;
        default: rst_wdt_cycles = '0;
      endcase
    end
  end

  // Captures fuse straps on the first edge after reset release and holds them.
  // Holding them keeps a fuse line that moves after reset from changing the clock under running code.
  // Blank fuses fall back to the shipped setting, so a fresh part always starts on the RC source.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_pend_q <= 1'b1;
      sel_q <= `CSSS_SHIP_SEL;
      sut_q <= `CSSS_SHIP_SUT;
      div8_q <= 1'b1;
      rstdis_q <= 1'b0;
    end else if (strap_pend_q) begin
      strap_pend_q <= 1'b0;
      if (fuses_blank_i) begin
        sel_q <= `CSSS_SHIP_SEL;
        sut_q <= `CSSS_SHIP_SUT;
        div8_q <= 1'b1;
        rstdis_q <= 1'b0;
      end else begin
        sel_q <= clk_src_sel_fuse_i;
        sut_q <= startup_time_sel_i;
        div8_q <= !div_by_eight_fuse_n_i;
        rstdis_q <= !reset_pin_disable_fuse_n_i;
      end
    end
  end

  // Start-up sequencer: 14 source cycles, then the watchdog-timed part, then run.
  // Wake is only taken while running, so a request during the reset delay cannot cut it short.
  // The wake flag ignores the done flag in the first cycle after the load, a guard against a stale one.
  // A reserved RC start-up field finishes the delay but never lets code run.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= CSSS_ST_RST_CK;
      ck_phase_q <= 1'b0;
      run_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end else begin
      case (state_q)
        CSSS_ST_RST_CK: begin
          run_q <= 1'b0;
          if (!strap_pend_q && !ck_phase_q) begin
            ck_phase_q <= 1'b1;
          end else if (ck_phase_q && cif.done) begin
            ck_phase_q <= 1'b0;
            if (rst_wdt_cycles == '0) begin
              state_q <= CSSS_ST_RUN;
              run_q <= !sut_reserved;
            end else begin
              state_q <= CSSS_ST_RST_WDT;
            end
          end
        end
        CSSS_ST_RST_WDT: begin
          if (cif.done) begin
            state_q <= CSSS_ST_RUN;
            run_q <= !sut_reserved;
          end
        end
        CSSS_ST_RUN: begin
          if (wake_req_i && run_q) begin
            state_q <= CSSS_ST_WAKE;
            run_q <= 1'b0;
            wake_seen_q <= 1'b1;
          end
        end
        CSSS_ST_WAKE: begin
          wake_seen_q <= 1'b0;
          if (cif.done && !wake_seen_q) begin
            state_q <= CSSS_ST_RUN;
            run_q <= 1'b1;
          end
        end
        default: state_q <= CSSS_ST_RST_CK;
      endcase
    end
  end

  // Counter load and tick selection for each phase.
  // The load and the phase step share one edge, so the watchdog tick is chosen on that edge already.
  // Nothing is loaded while straps are pending, so the 14 cycles count the captured source.
  always_comb begin
    cif.load = 1'b0;
    cif.count = `CSSS_CK_14;
    cif.tick = src_osc_tick_i;
    if (state_q == CSSS_ST_RST_CK && !strap_pend_q && !ck_phase_q) begin
      cif.load = 1'b1;
    end else if (state_q == CSSS_ST_RST_CK && ck_phase_q && cif.done) begin
      cif.load = 1'b1;
      cif.count = rst_wdt_cycles;
    end else if (state_q == CSSS_ST_RUN && wake_req_i && run_q) begin
      cif.load = 1'b1;
      cif.count = wake_cycles;
    end
    if (state_q == CSSS_ST_RST_WDT || (state_q == CSSS_ST_RST_CK && ck_phase_q && cif.done)) begin
      cif.tick = wdt_osc_tick_i;
    end
  end

  // One down counter serves every phase; only its load count and tick source change.
  csss_delay_counter u_cnt (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .cif(cif)
  );

  // Registered decode outputs.
  // They change one edge after the straps are captured and then stay put until the next reset.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xrange_q <= '0;
      src_q <= '0;
      div_q <= `CSSS_DIV8;
    end else begin
      xrange_q <= decode_range(sel_q[3:1]);
      src_q <= src;
      div_q <= div8_q ? `CSSS_DIV8 : `CSSS_DIV1;
    end
  end

  // AHB-Lite address phase capture.
  // Only the low address byte is decoded, so the register window repeats through the space.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= '0;
    end else if (hready_i) begin
      ap_valid_q <= bus_take(hsel_i, htrans_i, hready_i);
      ap_write_q <= hwrite_i;
      ap_addr_q <= haddr_i[7:0];
    end
  end

  // Write strobe for the trim register, live during the write's data phase.
  assign trim_wr = ap_valid_q && ap_write_q && ap_addr_q == `CSSS_ADDR_TRIM;

  // Trim register: factory value at reset, software writes apply at once.
  // The factory load on the first edge wins over any write that could meet it there.
  // A write takes effect on the edge that closes its data phase.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trim_q <= `CSSS_TRIM_RST;
      trim_load_q <= 1'b1;
    end else if (trim_load_q) begin
      trim_q <= factory_trim_i;
      trim_load_q <= 1'b0;
    end else if (trim_wr) begin
      trim_q <= hwdata_i[7:0];
    end
  end

  // Read data, registered one cycle after the address phase.
  // A trim write still in its data phase is forwarded, so a read right behind it sees the new value.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= '0;
    end else if (bus_take(hsel_i, htrans_i, hready_i) && !hwrite_i) begin
      case (haddr_i[7:0])
        `CSSS_ADDR_TRIM: rdata_q <= {24'h000000, trim_wr ? hwdata_i[7:0] : trim_q};
        `CSSS_ADDR_FUSE: rdata_q <= {26'h0000000, sut_q, sel_q};
        `CSSS_ADDR_CTRL: rdata_q <= {30'h0, rstdis_q, div8_q};
        `CSSS_ADDR_STAT: rdata_q <= {27'h0000000, run_q, src_q, xrange_q};
        default: rdata_q <= '0;
      endcase
    end
  end

  // Bus answer flags: no wait state and always OKAY, kept in flops so each output is registered.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // Trim drives the oscillator: bit 7 range, bits 6..0 monotonic fine step.
  assign rc_osc_trim_o = trim_q;
  assign hrdata_o = rdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = hresp_q;
  assign xtal_range_o = xrange_q;
  assign clk_src_o = src_q;
  assign sys_div_log2_o = div_q;
  assign cpu_run_o = run_q;
endmodule // csss_clock_startup

// [csss_clock_startup_properties.sv]
// Checker for the clock-source start-up select block.
// Assumes it is bound to csss_clock_startup and sees only its ports.
`timescale 1ns/100ps
module csss_clock_startup_chk (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] clk_src_sel_fuse_i,
  input wire logic [1:0] startup_time_sel_i,
  input wire logic div_by_eight_fuse_n_i,
  input wire logic reset_pin_disable_fuse_n_i,
  input wire logic fuses_blank_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic wake_req_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [7:0] rc_osc_trim_o,
  input wire logic [1:0] xtal_range_o,
  input wire logic [1:0] clk_src_o,
  input wire logic [1:0] sys_div_log2_o,
  input wire logic cpu_run_o
);
  logic [16:0] cnt_q;
  logic xt;
  logic rc;
  // Counts edges since reset release and saturates.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 17'h00000;
    end else if (cnt_q != 17'h1FFFF) begin
      cnt_q <= cnt_q + 17'h00001;
    end
  end
  // Fuse cases, valid once capture and decode have landed.
  assign xt = !fuses_blank_i && clk_src_sel_fuse_i[3] && cnt_q > 17'h00002;
  assign rc = !fuses_blank_i && clk_src_sel_fuse_i == 4'h2 && cnt_q > 17'h00002;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_XT_RANGE: assert property (xt |-> xtal_range_o == clk_src_sel_fuse_i[2:1] && clk_src_o == 2'h0)
    else $error("crystal range decode wrong");
  AST_RC_SEL: assert property (rc |-> clk_src_o == 2'h1)
    else $error("rc source not selected");
  AST_RUN_MIN: assert property ($rose(cpu_run_o) |-> cnt_q >= 17'h0000E)
    else $error("run before reset delay");
  AST_RSTDIS: assert property ($rose(cpu_run_o) && rc && !reset_pin_disable_fuse_n_i |-> cnt_q > 17'h01000)
    else $error("reset pin disable delay short");
  AST_RESERVED: assert property (rc && startup_time_sel_i == 2'h3 |-> !cpu_run_o)
    else $error("reserved start-up field ran");
  AST_SHIP: assert property (fuses_blank_i && cnt_q > 17'h00002 |-> clk_src_o == 2'h1 && sys_div_log2_o == 2'h3)
    else $error("shipped defaults wrong");
  AST_DIV: assert property (!fuses_blank_i && cnt_q > 17'h00002 |->
    sys_div_log2_o == (div_by_eight_fuse_n_i ? 2'h0 : 2'h3))
    else $error("divide fuse decode wrong");
  AST_TRIM_LOAD: assert property (cnt_q == 17'h00001 |-> rc_osc_trim_o == factory_trim_i)
    else $error("factory trim not loaded");
  AST_TRIM_WR: assert property (hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i == 32'h0 ##1 1'b1
    |=> rc_osc_trim_o == $past(hwdata_i[7:0]))
    else $error("trim write not applied");
  AST_WAKE: assert property (wake_req_i && cpu_run_o |-> ##[1:2] !cpu_run_o)
    else $error("wake did not stop run");
  // Main scenarios seen.
  COV_RUN: cover property ($rose(cpu_run_o));
  COV_WAKE: cover property (wake_req_i && cpu_run_o);
  COV_RSV: cover property (rc && startup_time_sel_i == 2'h3);
endmodule // csss_clock_startup_chk
bind csss_clock_startup csss_clock_startup_chk u_csss_clock_startup_chk (.ref_clk_i, .reset_n_i,
  .clk_src_sel_fuse_i, .startup_time_sel_i, .div_by_eight_fuse_n_i, .reset_pin_disable_fuse_n_i,
  .fuses_blank_i, .factory_trim_i, .wake_req_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
  .hready_i, .rc_osc_trim_o, .xtal_range_o, .clk_src_o, .sys_div_log2_o, .cpu_run_o);

// [csss_cnt_if.sv]
// Interface between the top module and the delay counter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
interface csss_cnt_if;
  import csss_pkg::*;
  logic load;
  csss_cnt_t count;
  logic tick;
  logic done;
  modport ctrl (output load, output count, output tick, input done);
  modport cnt (input load, input count, input tick, output done);
endinterface

// [csss_defines.svh]
// Constants for the clock-source start-up select block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef CSSS_DEFINES_SVH
`define CSSS_DEFINES_SVH
`define CSSS_ADDR_TRIM 8'h00
`define CSSS_ADDR_FUSE 8'h04
`define CSSS_ADDR_CTRL 8'h08
`define CSSS_ADDR_STAT 8'h0C
`define CSSS_ADDR_STRAP 8'h10
`define CSSS_SEL_RC 4'h2
`define CSSS_XT_MIN 4'h8
`define CSSS_XT_R0 3'h4
`define CSSS_XT_R1 3'h5
`define CSSS_XT_R2 3'h6
`define CSSS_XT_R3 3'h7
`define CSSS_SUT_00 2'h0
`define CSSS_SUT_01 2'h1
`define CSSS_SUT_10 2'h2
`define CSSS_SUT_11 2'h3
`define CSSS_SHIP_SEL 4'h2
`define CSSS_SHIP_SUT 2'h2
`define CSSS_CK_6 17'h00006
`define CSSS_CK_258 17'h00102
`define CSSS_CK_1K 17'h00400
`define CSSS_CK_16K 17'h04000
`define CSSS_CK_14 17'h0000E
`define CSSS_WDT_4K 17'h01000
`define CSSS_WDT_64K 17'h10000
`define CSSS_ONE 17'h00001
`define CSSS_DIV8 2'h3
`define CSSS_DIV1 2'h0
`define CSSS_TRIM_RST 8'h80
`endif

// [csss_delay_counter.sv]
// Down counter that times start-up and reset delays in clock ticks.
// Assumes tick marks one edge of the clock being counted.
`timescale 1ns/100ps
`include "csss_defines.svh"
module csss_delay_counter
  import csss_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  csss_cnt_if.cnt cif
);
  csss_cnt_t remain_q;
  logic done_q;

  // Loads a count and steps it down once per tick, flagging the last tick.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remain_q <= '0;
      done_q <= 1'b0;
    end else if (cif.load) begin
      remain_q <= cif.count;
      done_q <= 1'b0;
    end else if (cif.tick && remain_q != '0) begin
      remain_q <= remain_q - `CSSS_ONE;
      done_q <= (remain_q == `CSSS_ONE);
    end else begin
      done_q <= 1'b0;
    end
  end

  assign cif.done = done_q;
endmodule // csss_delay_counter

// [csss_osc_model.sv]
// Behavioural resonator and watchdog oscillator as one-cycle ticks.
// Assumes the reference clock is faster than both oscillators.
`timescale 1ns/100ps
module csss_osc_model (
  input wire logic clk_i,
  input wire logic slow_i,
  output logic src_tick_o,
  output logic wdt_tick_o
);
  logic ph_q = 1'b0;
  // A ceramic resonator, so the lowest range is fair; slow mode ticks every other cycle.
  always @(posedge clk_i) begin
    ph_q <= !ph_q;
    src_tick_o <= !slow_i || ph_q;
    wdt_tick_o <= !slow_i || ph_q;
  end
endmodule // csss_osc_model

// [csss_pkg.sv]
// Types for the clock-source start-up select block.
// Assumes csss_defines.svh is on the include path.
`include "csss_defines.svh"
package csss_pkg;
  typedef enum logic [1:0] {CSSS_SRC_XTAL, CSSS_SRC_RC, CSSS_SRC_OTHER} csss_src_t;
  typedef enum logic [1:0] {CSSS_XR_LOW, CSSS_XR_MID, CSSS_XR_HIGH, CSSS_XR_TOP} csss_xrange_t;
  typedef enum logic [2:0] {CSSS_ST_RST_CK, CSSS_ST_RST_WDT, CSSS_ST_RUN, CSSS_ST_WAKE} csss_state_t;
  typedef logic [16:0] csss_cnt_t;
endpackage

// [csss_testbench.sv]
// Self-checking bench for the clock-source start-up select block.
// Assumes the bus answers within the wait bound and ticks come from the oscillator model.
`timescale 1ns/100ps
module testbench;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, div_by_eight_fuse_n_i = 1'b1;
  logic reset_pin_disable_fuse_n_i = 1'b1, fuses_blank_i = 1'b0, wake_req_i = 1'b0;
  logic [3:0] clk_src_sel_fuse_i = 4'h2;
  logic [1:0] startup_time_sel_i = 2'h0, htrans_i = 2'h0;
  logic [7:0] factory_trim_i = 8'h5A;
  logic hsel_i = 1'b0, hwrite_i = 1'b0, osc_slow = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, r;
  logic [2:0] hsize_i = 3'h2;
  logic wdt_osc_tick_i, src_osc_tick_i, hready_i, hreadyout_o, hresp_o, cpu_run_o;
  logic [7:0] rc_osc_trim_o;
  logic [1:0] xtal_range_o, clk_src_o, sys_div_log2_o;
  logic [7:0] tv [3] = '{8'h7F, 8'h80, 8'h00};
  int errors = 0, n_tests = 0;
  assign hready_i = hreadyout_o;
  always #12.5 ref_clk_i = ~ref_clk_i;
  csss_clock_startup u_csss_clock_startup (.ref_clk_i, .reset_n_i, .clk_src_sel_fuse_i, .startup_time_sel_i,
    .div_by_eight_fuse_n_i, .reset_pin_disable_fuse_n_i, .fuses_blank_i, .factory_trim_i, .wdt_osc_tick_i,
    .src_osc_tick_i, .wake_req_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .rc_osc_trim_o, .xtal_range_o, .clk_src_o, .sys_div_log2_o, .cpu_run_o);
  csss_osc_model u_csss_osc_model (.clk_i(ref_clk_i), .slow_i(osc_slow), .src_tick_o(src_osc_tick_i),
    .wdt_tick_o(wdt_osc_tick_i));
  task test_done;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Samples ready and read data before each edge, bounded.
  task wait_rdy(output logic [31:0] d);
    int k;
    logic rdy;
    k = 0;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(negedge ref_clk_i);
      rdy = hready_i;
      d = hrdata_o;
      @(posedge ref_clk_i);
      k++;
      if (k > 20) begin
        errors++;
        $display("BAD t=%0t ready %h %h", $time, rdy, 1'b1);
        test_done;
      end
    end
  endtask
  // One single word transfer: address phase, then data phase.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    wait_rdy(q);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy(q);
  endtask
  task do_rst(input logic [3:0] sel, input logic [1:0] sut, input logic rd_n, input logic bl, input logic dn);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    clk_src_sel_fuse_i <= sel;
    startup_time_sel_i <= sut;
    reset_pin_disable_fuse_n_i <= rd_n;
    fuses_blank_i <= bl;
    div_by_eight_fuse_n_i <= dn;
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
  endtask
  task wait_run(input int exp);
    int k;
    k = 0;
    while (cpu_run_o !== 1'b1) begin
      @(negedge ref_clk_i);
      k++;
      if (k > exp + 12) begin
        errors++;
        $display("BAD t=%0t run late %h %h", $time, k, exp);
        test_done;
      end
    end
    chk(k + 8 > exp, 1'b1);
  endtask
  // Reset delay, decode and wake start-up for one fuse setting; negative delay means it must stay stopped.
  task run_case(input logic [3:0] sel, input logic [1:0] sut, input logic rd_n, input int rst, input int wk);
    int m;
    m = osc_slow ? 2 : 1;
    do_rst(sel, sut, rd_n, 1'b0, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    chk(clk_src_o, sel[3] ? 2'h0 : 2'h1);
    chk(sys_div_log2_o, 2'h0);
    if (sel[3]) chk(xtal_range_o, sel[2:1]);
    @(posedge ref_clk_i);
    bus(1'b0, 32'h8, 32'h0, r);
    chk(r, {30'h0, !rd_n, 1'b0});
    if (rst < 0) begin
      repeat (4200) @(negedge ref_clk_i);
      chk(cpu_run_o, 1'b0);
    end else begin
      wait_run(m * (14 + rst));
      if (sel[3]) begin
        @(posedge ref_clk_i);
        bus(1'b0, 32'hC, 32'h0, r);
        chk(r, {27'h0, 1'b1, 2'h0, sel[2:1]});
      end
      if (wk > 0) begin
        @(posedge ref_clk_i);
        wake_req_i <= 1'b1;
        @(posedge ref_clk_i);
        wake_req_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(cpu_run_o, 1'b0);
        wait_run(m * wk);
      end
    end
  endtask
  // Factory trim load, trim writes with read-back, unmapped place, fuse register.
  task t_trim;
    do_rst(4'hF, 2'h1, 1'b1, 1'b0, 1'b1);
    repeat (2) @(posedge ref_clk_i);
    bus(1'b0, 32'h0, 32'h0, r);
    chk(r, {24'h000000, factory_trim_i});
    // No memory writes here, so any trim value is safe.
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 32'h0, {24'h0, tv[i]}, r);
      bus(1'b0, 32'h0, 32'h0, r);
      chk(r, {24'h0, tv[i]});
      chk(rc_osc_trim_o, tv[i]);
    end
    bus(1'b1, 32'h20, 32'hFFFFFFFF, r);
    bus(1'b0, 32'h20, 32'h0, r);
    chk(r, 32'h0);
    chk(rc_osc_trim_o, 8'h00);
    bus(1'b0, 32'h4, 32'h0, r);
    chk(r, 32'h1F);
    chk(hresp_o, 1'b0);
  endtask
  task t_ship;
    do_rst(4'h0, 2'h0, 1'b1, 1'b1, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    chk(clk_src_o, 2'h1);
    chk(sys_div_log2_o, 2'h3);
    do_rst(4'h2, 2'h0, 1'b1, 1'b0, 1'b0);
    repeat (3) @(negedge ref_clk_i);
    chk(sys_div_log2_o, 2'h3);
    do_rst(4'h0, 2'h0, 1'b1, 1'b0, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    chk(clk_src_o, 2'h2);
  endtask
  initial begin
    t_trim;
    t_ship;
    run_case(4'h8, 2'h0, 1'b1, 4096, 258);
    run_case(4'hE, 2'h1, 1'b1, -1, 0);
    run_case(4'hA, 2'h2, 1'b1, 0, 1024);
    run_case(4'hC, 2'h3, 1'b1, 4096, 1024);
    run_case(4'h9, 2'h0, 1'b1, -1, 0);
    run_case(4'hF, 2'h1, 1'b1, 0, 16384);
    run_case(4'hD, 2'h2, 1'b1, 4096, 0);
    osc_slow = 1'b1;
    run_case(4'h2, 2'h0, 1'b1, 0, 6);
    osc_slow = 1'b0;
    run_case(4'h2, 2'h1, 1'b1, 4096, 6);
    run_case(4'h2, 2'h2, 1'b1, -1, 0);
    run_case(4'h2, 2'h3, 1'b1, -1, 0);
    run_case(4'h2, 2'h0, 1'b0, 4096, 0);
    test_done;
  end
endmodule // testbench
